// [core/dcs_core.sv]
/*
  Synthesizer core with system clock selection controls: buffered and
  active configuration words, commit on the update pin, 32-bit phase
  accumulator, cosine converter and clock path decode.
  Assumes clk_sys is the core sample clock; pins are asynchronous to it.
*/
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcs_core #(
  parameter int LOCK_CYCLES = dcs_pkg::LOCK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  // Register port
  input  wire logic [dcs_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [dcs_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [dcs_pkg::DATA_W-1:0]    reg_rdata_ff,
  // Device pins
  input  wire logic                          io_update_pin,
  input  wire logic                          oscillator_select_pin,
  // Clock path controls and converter code
  output var dcs_pkg::dcs_clk_ctrl_t         clk_ctrl_ff,
  output logic      [dcs_pkg::DAC_W-1:0]     dac_code
);

  // Pin synchronisers
  logic [1:0] upd_sync_ff;
  logic [1:0] osc_sync_ff;
  logic       upd_last_ff;
  logic       commit;

  // Configuration words
  dcs_pkg::dcs_cfg_t buf_ff;
  dcs_pkg::dcs_cfg_t act_ff;
  dcs_pkg::dcs_cfg_t nxt_buf;
  dcs_pkg::dcs_cfg_t nxt_act;

  // Core state
  logic [dcs_pkg::PHASE_W-1:0] acc_ff;
  logic [dcs_pkg::PHASE_W-1:0] nxt_acc;
  logic [dcs_pkg::PHASE_W-1:0] lut_phase;
  logic [dcs_pkg::LOCK_W-1:0]  lock_cnt_ff;
  logic [dcs_pkg::LOCK_W-1:0]  nxt_lock_cnt;
  logic [dcs_pkg::DATA_W-1:0]  nxt_rdata;
  dcs_pkg::dcs_clk_ctrl_t      nxt_clk_ctrl;

  // Decoded controls from the active words, plus the buffered multiplier, the select pin and the lock state
  logic [dcs_pkg::MULT_W-1:0]  mult_act;
  logic [dcs_pkg::MULT_W-1:0]  mult_buf;
  logic                        pll_on;
  logic                        clk_gated;
  logic                        clr_act;
  logic                        sine_sel;
  logic                        osc_sel;
  logic                        settled;

  // Two-stage synchronisers; only stage two is read by logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upd_sync_ff <= 2'b00;
      osc_sync_ff <= 2'b00;
      upd_last_ff <= 1'b0;
    end else if (clk_en) begin
      upd_sync_ff <= {upd_sync_ff[0], io_update_pin};
      osc_sync_ff <= {osc_sync_ff[0], oscillator_select_pin};
      upd_last_ff <= upd_sync_ff[1];
    end
  end

  // Rising edge of the update pin transfers the buffers
  assign commit  = upd_sync_ff[1] && !upd_last_ff;
  assign osc_sel = osc_sync_ff[1];

  // Field decode, multiplier kept apart from the gate bit
  always_comb begin
    mult_act  = act_ff.cw2[dcs_pkg::CW2_MULT_MSB:dcs_pkg::CW2_MULT_LSB];
    mult_buf  = buf_ff.cw2[dcs_pkg::CW2_MULT_MSB:dcs_pkg::CW2_MULT_LSB];
    pll_on    = (mult_act >= dcs_pkg::MULT_MIN)
                && (mult_act <= dcs_pkg::MULT_MAX);
    clk_gated = act_ff.cw1[dcs_pkg::CW1_CLKGATE_BIT];
    clr_act   = act_ff.cw1[dcs_pkg::CW1_CLR_BIT];
    sine_sel  = act_ff.cw1[dcs_pkg::CW1_SINE_BIT];
    settled   = (lock_cnt_ff == '0);
  end

  // Register writes land in the buffers; commit copies them to active
  always_comb begin
    nxt_buf = buf_ff;
    nxt_act = act_ff;
    if (reg_wr) begin
      case (reg_addr)
        dcs_pkg::OFS_CW1: begin
          nxt_buf.cw1 = reg_wdata;
        end
        dcs_pkg::OFS_CW2: begin
          nxt_buf.cw2 = reg_wdata[dcs_pkg::CW2_W-1:0];
        end
        dcs_pkg::OFS_FSW: begin
          nxt_buf.fsw = reg_wdata;
        end
        default: begin
          nxt_buf = buf_ff; // Unmapped writes are dropped
        end
      endcase
    end
    // A write in the commit cycle lands in the buffer, not in active
    if (commit) begin
      nxt_act = buf_ff;
    end
  end

  // Register file storage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_ff <= '{cw1: dcs_pkg::CW1_BUF_RST, cw2: dcs_pkg::CW2_RST,
                  fsw: dcs_pkg::FSW_RST};
      act_ff <= '{cw1: dcs_pkg::CW1_ACT_RST, cw2: dcs_pkg::CW2_RST,
                  fsw: dcs_pkg::FSW_RST};
    end else if (clk_en) begin
      buf_ff <= nxt_buf;
      act_ff <= nxt_act;
    end
  end

  // Phase accumulator; a gated clock stops it where it stands
  always_comb begin
    nxt_acc = acc_ff;
    if (clk_gated) begin
      nxt_acc = acc_ff;
    end else if (clr_act) begin
      nxt_acc = '0;
    end else begin
      // Carry out of bit 31 is dropped by width; zero step holds phase
      nxt_acc = acc_ff + act_ff.fsw;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (clk_en) begin
      acc_ff <= nxt_acc;
    end
  end

  // Sine output is cosine a quarter turn late
  assign lut_phase = sine_sel ? (acc_ff - dcs_pkg::QUARTER) : acc_ff;

  // Converter code; frozen with the gated clock as the real path would be
  dcs_cos_lut u_cos_lut (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .ce          (clk_en && !clk_gated),
    .phase       (lut_phase),
    .dac_code_ff (dac_code)
  );

  // Lock wait counter, restarted whenever a commit changes the multiplier
  always_comb begin
    nxt_lock_cnt = lock_cnt_ff;
    if (commit && (mult_buf != mult_act)) begin
      nxt_lock_cnt = dcs_pkg::LOCK_W'(LOCK_CYCLES);
    end else if (lock_cnt_ff != '0) begin
      nxt_lock_cnt = lock_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_cnt_ff <= '0;
    end else if (clk_en) begin
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end

  // Clock path controls; oscillator never stops for the gate bit
  always_comb begin
    nxt_clk_ctrl.osc_enable         = osc_sel;
    nxt_clk_ctrl.crystal_out_enable = osc_sel
                                      && act_ff.cw2[dcs_pkg::CW2_XOUT_BIT];
    nxt_clk_ctrl.clk_in_buf_enable  = !clk_gated;
    nxt_clk_ctrl.pll_enable         = pll_on;
    nxt_clk_ctrl.pll_mult           = pll_on ? mult_act : '0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_ctrl_ff <= '0;
    end else if (clk_en) begin
      clk_ctrl_ff <= nxt_clk_ctrl;
    end
  end

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        dcs_pkg::OFS_CW1: begin
          nxt_rdata = buf_ff.cw1;
        end
        dcs_pkg::OFS_CW2: begin
          nxt_rdata = {{(dcs_pkg::DATA_W-dcs_pkg::CW2_W){1'b0}}, buf_ff.cw2};
        end
        dcs_pkg::OFS_FSW: begin
          nxt_rdata = buf_ff.fsw;
        end
        dcs_pkg::OFS_STATUS: begin
          nxt_rdata[dcs_pkg::ST_CLR_BIT]     = clr_act;
          nxt_rdata[dcs_pkg::ST_PLL_BIT]     = pll_on;
          nxt_rdata[dcs_pkg::ST_OSC_BIT]     = osc_sel;
          nxt_rdata[dcs_pkg::ST_SETTLED_BIT] = settled;
          nxt_rdata[dcs_pkg::ST_GATED_BIT]   = clk_gated;
        end
        dcs_pkg::OFS_PHASE: begin
          nxt_rdata = acc_ff;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= '0;
    end else if (clk_en) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule
`default_nettype wire

// [core/dcs_pkg.sv]
/*
  Constants, field layouts and carrier types for the synthesizer core and
  its system clock selection logic.
  Assumes one clock domain (the core sample clock) and a plain register port.
*/
// Summary of operation
// - Phase accumulator wraps modulo two to 32nd.
// - Zero step word holds present phase.
// - Clear bit forces accumulator to zero phase.
// - Clear bit active, buffer clear after reset.
// - Cosine lookup drives 14-bit converter code.
// - Multiplier field 4 to 20 enables PLL.
// - Other multiplier values bypass, PLL off.
// - Select pin enables oscillator; output buffer also needs bit 9.
// - Gate bit stops clock, oscillator stays.
// - Control word two bit 9 drives oscillator output.
// - Multiplier decoded apart from gate bit.
package dcs_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CW2_W  = 24;

  // Register offsets
  localparam logic [7:0] OFS_CW1    = 8'h00;
  localparam logic [7:0] OFS_CW2    = 8'h01;
  localparam logic [7:0] OFS_FSW    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PHASE  = 8'h11;

  // Reset values: active clear bit set, its buffer clear
  localparam logic [31:0] CW1_ACT_RST = 32'h0000_0400;
  localparam logic [31:0] CW1_BUF_RST = 32'h0000_0000;
  localparam logic [23:0] CW2_RST     = 24'h00_0000;
  localparam logic [31:0] FSW_RST     = 32'h0000_0000;

  // Field positions
  localparam int CW1_CLKGATE_BIT = 4;
  localparam int CW1_CLR_BIT     = 10;
  localparam int CW1_SINE_BIT    = 12;
  localparam int CW2_MULT_LSB    = 3;
  localparam int CW2_MULT_MSB    = 7;
  localparam int CW2_XOUT_BIT    = 9;

  // Status register bit positions
  localparam int ST_CLR_BIT     = 0;
  localparam int ST_PLL_BIT     = 1;
  localparam int ST_OSC_BIT     = 2;
  localparam int ST_SETTLED_BIT = 3;
  localparam int ST_GATED_BIT   = 4;

  // Multiplier range
  localparam int         MULT_W   = 5;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;

  // Datapath widths
  localparam int              PHASE_W   = 32;
  localparam int              DAC_W     = 14;
  localparam int              LUT_IDX_W = 4;
  localparam int              MAG_W     = 13;
  localparam logic [13:0]     DAC_MID   = 14'h2000;
  localparam logic [31:0]     QUARTER   = 32'h4000_0000;

  // PLL lock wait, figure in microseconds, count at the sample clock rate
  localparam int PLL_LOCK_US = 1000;
  localparam int CLK_MHZ     = 250;
  localparam int LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;
  localparam int LOCK_W      = 18;

  // Configuration words as seen by software
  typedef struct packed {
    logic [31:0] cw1;
    logic [23:0] cw2;
    logic [31:0] fsw;
  } dcs_cfg_t;

  // Controls toward the analog clock path
  typedef struct packed {
    logic             osc_enable;
    logic             crystal_out_enable;
    logic             clk_in_buf_enable;
    logic             pll_enable;
    logic [MULT_W-1:0] pll_mult;
  } dcs_clk_ctrl_t;

endpackage

// [core/dcs_cos_lut.sv]
/*
  Phase to amplitude converter: quarter-wave cosine table, offset-binary
  converter code registered at the output.
  Assumes phase from the same clock domain; ce freezes the output.
*/
`timescale 1ns/1ps
`default_nettype none
module dcs_cos_lut (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Phase in, code out
  input  wire logic [dcs_pkg::PHASE_W-1:0]  phase,
  output logic      [dcs_pkg::DAC_W-1:0]    dac_code_ff
);

  logic [dcs_pkg::DAC_W-1:0]       nxt_dac_code;
  logic [1:0]                      quad;
  logic [dcs_pkg::LUT_IDX_W-1:0]   idx;
  logic [dcs_pkg::MAG_W-1:0]       mag;
  logic                            neg;

  // Cosine of idx times pi over 32, full scale 8191
  function automatic logic [12:0] cos_tab(input logic [4:0] k);
    case (k)
      5'd0:    cos_tab = 13'h1fff;
      5'd1:    cos_tab = 13'h1fd8;
      5'd2:    cos_tab = 13'h1f62;
      5'd3:    cos_tab = 13'h1e9e;
      5'd4:    cos_tab = 13'h1d90;
      5'd5:    cos_tab = 13'h1c38;
      5'd6:    cos_tab = 13'h1a9b;
      5'd7:    cos_tab = 13'h18bc;
      5'd8:    cos_tab = 13'h16a0;
      5'd9:    cos_tab = 13'h144c;
      5'd10:   cos_tab = 13'h11c7;
      5'd11:   cos_tab = 13'h0f15;
      5'd12:   cos_tab = 13'h0c3f;
      5'd13:   cos_tab = 13'h094a;
      5'd14:   cos_tab = 13'h063e;
      5'd15:   cos_tab = 13'h0323;
      default: cos_tab = 13'h0000;
    endcase
  endfunction

  // Quadrant folding keeps the table a quarter wave
  always_comb begin
    quad = phase[dcs_pkg::PHASE_W-1 -: 2];
    idx  = phase[dcs_pkg::PHASE_W-3 -: dcs_pkg::LUT_IDX_W];
    case (quad)
      2'd0:    mag = cos_tab({1'b0, idx});
      2'd1:    mag = cos_tab(5'd16 - {1'b0, idx});
      2'd2:    mag = cos_tab({1'b0, idx});
      default: mag = cos_tab(5'd16 - {1'b0, idx});
    endcase
    neg = (quad == 2'd1) || (quad == 2'd2);
    nxt_dac_code = neg ? (dcs_pkg::DAC_MID - {1'b0, mag})
                       : (dcs_pkg::DAC_MID + {1'b0, mag});
  end

  // Registered code toward the converter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dac_code_ff <= dcs_pkg::DAC_MID;
    end else if (ce) begin
      dac_code_ff <= nxt_dac_code;
    end
  end

endmodule
`default_nettype wire

// [testbench/dcs_core_properties.sv]
/*
  Checker for the clock path controls and converter code of dcs_core.
  Assumes binding to dcs_core; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dcs_core_properties #(
  parameter int LOCK_CYCLES = 20
) (
  // Clock, reset, enable
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire logic                       clk_en,
  // Register port
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata_ff,
  // Pins and outputs
  input wire logic                       io_update_pin,
  input wire logic                       oscillator_select_pin,
  input wire dcs_pkg::dcs_clk_ctrl_t     clk_ctrl_ff,
  input wire logic [13:0]                dac_code
);
  logic [1:0] age_ff;
  logic       seen_ff;

  // Age since reset and update history; early samples see reset values
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      age_ff  <= 2'h0;
      seen_ff <= 1'b0;
    end else begin
      age_ff  <= (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
      seen_ff <= seen_ff | io_update_pin;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_pll_range;
    clk_ctrl_ff.pll_enable |-> clk_ctrl_ff.pll_mult inside {[5'h04:5'h14]};
  endproperty
  a_pll_range: assert property (p_pll_range) else $error("pll on, bad factor");
  property p_bypass;
    !clk_ctrl_ff.pll_enable |-> clk_ctrl_ff.pll_mult == 5'h00;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass keeps factor");
  property p_xout;
    clk_ctrl_ff.crystal_out_enable |-> clk_ctrl_ff.osc_enable;
  endproperty
  a_xout: assert property (p_xout) else $error("buffer on, osc off");
  property p_osc_on;
    (age_ff == 2'h3 && oscillator_select_pin && clk_en)[*3] |=> clk_ctrl_ff.osc_enable;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("osc not enabled");
  property p_osc_off;
    (!oscillator_select_pin && clk_en)[*3]
      |=> !clk_ctrl_ff.osc_enable && !clk_ctrl_ff.crystal_out_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc not disabled");
  property p_gate_freeze;
    age_ff == 2'h3 && !clk_ctrl_ff.clk_in_buf_enable
      && !$past(clk_ctrl_ff.clk_in_buf_enable) |-> $stable(dac_code);
  endproperty
  a_gate_freeze: assert property (p_gate_freeze) else $error("gated code moved");
  property p_clear_hold;
    age_ff == 2'h3 && !seen_ff |-> dac_code == 14'h3fff;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("not held at zero");
  property p_commit_only;
    age_ff == 2'h3 && $changed({clk_ctrl_ff.pll_mult, clk_ctrl_ff.clk_in_buf_enable})
      |-> $past(io_update_pin, 4);
  endproperty
  a_commit_only: assert property (p_commit_only) else $error("ctrl moved alone");

  // Main scenarios reached
  c_pll: cover property (clk_ctrl_ff.pll_enable && clk_ctrl_ff.pll_mult == 5'h14);
  c_gate: cover property (!clk_ctrl_ff.clk_in_buf_enable && clk_ctrl_ff.pll_enable);
  c_osc_off: cover property (age_ff == 2'h3 && !clk_ctrl_ff.osc_enable);
endmodule
`default_nettype wire

bind dcs_core dcs_core_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .io_update_pin(io_update_pin), .oscillator_select_pin(oscillator_select_pin),
  .clk_ctrl_ff(clk_ctrl_ff), .dac_code(dac_code)
);

// [testbench/dcs_ref_src.sv]
/*
  Reference source model: board strap on the select pin and the
  resulting sample rate. Assumes controls come from dcs_core.
*/
`timescale 1ns/1ps
`default_nettype none
module dcs_ref_src #(
  parameter int REF_MHZ = 20
) (
  // Board strap and clock path controls
  input  wire logic                   strap,
  input  wire dcs_pkg::dcs_clk_ctrl_t ctrl,
  // Select pin and sample rate
  output logic                        oscillator_select_pin,
  output var int                      core_sample_clock_mhz
);
  assign oscillator_select_pin = strap;
  // Gate wins; 20 MHz times at most 20 keeps within 400
  always_comb begin
    if (!ctrl.clk_in_buf_enable) core_sample_clock_mhz = 0;
    else if (ctrl.pll_enable) core_sample_clock_mhz = REF_MHZ * int'(ctrl.pll_mult);
    else core_sample_clock_mhz = REF_MHZ;
  end
endmodule
`default_nettype wire

// [testbench/dcs_core_tb_top.sv]
/*
  Testbench for dcs_core: register tasks, update pulses, clock path.
  Assumes a 250 MHz sample clock and the reference source model.
*/
`timescale 1ns/1ps
`default_nettype none
module dcs_core_tb_top;
  logic clk_sys, rst, clk_en, reg_wr, reg_rd, io_update_pin, strap, sel;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff;
  logic [13:0] dac_code;
  dcs_pkg::dcs_clk_ctrl_t ctrl;
  int sys_mhz, err_total, cmp_count;

  dcs_core #(.LOCK_CYCLES(20)) u_dcs_core (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .io_update_pin(io_update_pin),
    .oscillator_select_pin(sel), .clk_ctrl_ff(ctrl), .dac_code(dac_code));
  dcs_ref_src u_dcs_ref_src (.strap(strap), .ctrl(ctrl),
    .oscillator_select_pin(sel), .core_sample_clock_mhz(sys_mhz));

  // Sample clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Two back-to-back reads of one place
  task automatic rd(input logic [7:0] a, output logic [31:0] d0, output logic [31:0] d1);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    #1 d0 = reg_rdata_ff;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d1 = reg_rdata_ff;
  endtask
  // Pin held two cycles so the synchroniser cannot miss it
  task automatic upd;
    @(posedge clk_sys);
    io_update_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    io_update_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #40000;
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] d0, d1;
    logic [4:0]  ms [6];
    logic        en;
    ms = '{5'h04, 5'h00, 5'h15, 5'h03, 5'h1f, 5'h14};
    {rst, clk_en, strap} = 3'b111;
    {reg_wr, reg_rd, io_update_pin, reg_addr, reg_wdata} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(dcs_pkg::OFS_STATUS, d0, d1);
    chk(d0 & 32'h0000_0007, 32'h0000_0005);
    rd(dcs_pkg::OFS_PHASE, d0, d1);
    chk(d0 | d1, 32'h0000_0000);
    chk({18'h0, dac_code}, 32'h0000_3fff);
    rd(dcs_pkg::OFS_CW1, d0, d1);
    chk(d0, 32'h0000_0000);
    rd(8'h20, d0, d1);
    chk(d0, 32'h0000_0000);
    wr(dcs_pkg::OFS_FSW, 32'hf000_0001);
    wr(dcs_pkg::OFS_CW1, 32'h0000_0000);
    upd();
    rd(dcs_pkg::OFS_PHASE, d0, d1);
    chk(d1 - d0, 32'hf000_0001);
    chk(d0 + 32'hf000_0001, d1);
    wr(dcs_pkg::OFS_FSW, 32'h0000_0000);
    upd();
    rd(dcs_pkg::OFS_PHASE, d0, d1);
    chk(d1, d0);
    wr(dcs_pkg::OFS_CW1, 32'h0000_0400);
    upd();
    rd(dcs_pkg::OFS_PHASE, d0, d1);
    chk(d0, 32'h0000_0000);
    chk({18'h0, dac_code}, 32'h0000_3fff);
    // Sine at zero phase sits at midscale
    wr(dcs_pkg::OFS_CW1, 32'h0000_1400);
    upd();
    chk({18'h0, dac_code}, 32'h0000_2000);
    // Every factor differs from the last, so each one restarts lock
    foreach (ms[i]) begin
      en = ms[i] >= 5'h04 && ms[i] <= 5'h14;
      // Output buffer bit follows en so both of its levels are seen
      wr(dcs_pkg::OFS_CW2, {22'h0, en, 1'b0, ms[i], 3'h0});
      upd();
      chk(32'(ctrl), {23'h0, 1'b1, en, 1'b1, en, en ? ms[i] : 5'h00});
      chk(32'(sys_mhz), en ? 32'(20 * int'(ms[i])) : 32'h0000_0014);
      rd(dcs_pkg::OFS_STATUS, d0, d1);
      chk(d0 & 32'h0000_001e, {27'h0, 3'b001, en, 1'b0});
      repeat (25) @(posedge clk_sys);
      rd(dcs_pkg::OFS_STATUS, d0, d1);
      chk(d0 & 32'h0000_001e, {27'h0, 3'b011, en, 1'b0});
    end
    wr(dcs_pkg::OFS_FSW, 32'hf000_0001);
    wr(dcs_pkg::OFS_CW1, 32'h0000_0000);
    upd(); // Phase must be moving for the gate to show
    wr(dcs_pkg::OFS_CW1, 32'h0000_0010);
    upd();
    rd(dcs_pkg::OFS_PHASE, d0, d1);
    chk(d1, d0);
    rd(dcs_pkg::OFS_STATUS, d0, d1);
    chk(d0 & 32'h0000_0010, 32'h0000_0010);
    chk(32'(ctrl), {23'h0, 3'b110, 1'b1, 5'h14});
    wr(dcs_pkg::OFS_CW1, 32'h0000_0000);
    upd();
    rd(dcs_pkg::OFS_PHASE, d0, d1);
    chk(d1 - d0, 32'hf000_0001);
    @(posedge clk_sys);
    strap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk(32'(ctrl), {23'h0, 3'b001, 1'b1, 5'h14});
    @(posedge clk_sys);
    strap <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk(32'(ctrl), {23'h0, 3'b111, 1'b1, 5'h14});
    give_verdict();
  end
endmodule
`default_nettype wire
